// ### hw/rcc_pkg.sv
// package of the calendar counter chain: offsets, layouts, reset values
// assumes byte addresses on a 20-bit register port, 8-bit data
package rcc_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [19:0] ADDR_SEC    = 20'hF_FF92;
  localparam logic [19:0] ADDR_MIN    = 20'hF_FF93;
  localparam logic [19:0] ADDR_HOUR   = 20'hF_FF94;
  localparam logic [19:0] ADDR_WEEK   = 20'hF_FF95;
  localparam logic [19:0] ADDR_DAY    = 20'hF_FF96;
  localparam logic [19:0] ADDR_MONTH  = 20'hF_FF97;
  localparam logic [19:0] ADDR_YEAR   = 20'hF_FF98;
  localparam logic [19:0] ADDR_CTRL0  = 20'hF_FF9D;
  localparam logic [19:0] ADDR_CTRL1  = 20'hF_FF9E;

  // ------------------------------------------------------------
  // counter indices
  // ------------------------------------------------------------
  localparam int NUM_CNT   = 7;
  localparam logic [2:0] IDX_SEC   = 3'h0;
  localparam logic [2:0] IDX_MIN   = 3'h1;
  localparam logic [2:0] IDX_HOUR  = 3'h2;
  localparam logic [2:0] IDX_WEEK  = 3'h3;
  localparam logic [2:0] IDX_DAY   = 3'h4;
  localparam logic [2:0] IDX_MONTH = 3'h5;
  localparam logic [2:0] IDX_YEAR  = 3'h6;

  // ------------------------------------------------------------
  // reset values and implemented bits, year down to seconds
  // ------------------------------------------------------------
  localparam logic [6:0][7:0] CNT_RST  = 56'h00_01_01_00_12_00_00;
  localparam logic [6:0][7:0] CNT_MASK = 56'hFF_1F_3F_07_3F_7F_7F;

  // ------------------------------------------------------------
  // field positions and limits
  // ------------------------------------------------------------
  localparam int BIT_RUN_EN   = 7;
  localparam int BIT_HOUR_FMT = 3;
  localparam int BIT_WAIT_ST  = 1;
  localparam int BIT_WAIT_CTL = 0;
  localparam int BIT_PM       = 5;
  localparam logic [7:0]  MAX_SEC     = 8'h59;
  localparam logic [7:0]  MAX_WEEK    = 8'h06;
  localparam logic [7:0]  MAX_MONTH   = 8'h12;
  localparam logic [7:0]  MAX_YEAR    = 8'h99;
  localparam logic [7:0]  FIRST_ONE   = 8'h01;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [15:0] SUBSEC_DEF  = 16'h7FFF;

  // ------------------------------------------------------------
  // buffered counter write
  // ------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [2:0] idx;
    logic [7:0] data;
  } rcc_wr_t;

endpackage

// ### hw/rcc_calendar.sv
// calendar counter chain: seconds to year, with hour format and wait
// assumes strobes synchronous to I_CLK, one strobe per cycle at most

// Contract
// - seconds run BCD 00..59, step on each sub-second overflow
// - counter writes go via a buffer, live within two cycles
// - writing seconds clears the sub-second counter
// - minutes run BCD 00..59, step when seconds leave 59
// - a counter being written drops its incoming carry
// - hours step on minute wrap, 24h 00..23 or 12h 01..12, 21..32
// - format bit 3 of control zero: 0 is 12-hour, 1 is 24-hour
// - changing the format converts the current hour encoding
// - in 12-hour mode bit 5 marks PM; midnight 12H, noon 32H
// - hour resets to 12H, reads 00H once 24-hour is chosen
// - day steps on hour wrap, up to 31, 30, 29 or 28
// - month length by month number and leap year
// - weekday runs 0..6 and steps with every day advance
// - weekday not derived from date; software loads it
// - month runs BCD 01..12, steps past the last day
// - year runs BCD 00..99, steps on month wrap
// - years divisible by four, 00 included, are leap years
// - reset: day and month 01H; sec, min, week, year 00H
// - wait bit freezes counters; software waits for status 1
// - wait status follows the wait bit within one cycle
// - overflow during wait is held, unless seconds written
module rcc_calendar #(
  parameter logic [15:0] SUBSEC_LIMIT = rcc_pkg::SUBSEC_DEF
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic [19:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [7:0]  O_RDATA
);

  // ------------------------------------------------------------
  // bcd and calendar functions
  // ------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      r = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction

  function automatic logic [7:0] bcd_wrap(input logic [7:0] v,
                                          input logic [7:0] top,
                                          input logic [7:0] low);
    return (v == top) ? low : bcd_inc(v);
  endfunction

  function automatic logic [6:0] bcd2bin(input logic [7:0] v);
    return 7'(7'(v[7:4]) * 7'd10 + 7'(v[3:0]));
  endfunction

  function automatic logic [7:0] bin2bcd(input logic [6:0] b);
    return {4'(b / 7'd10), 4'(b % 7'd10)};
  endfunction

  function automatic logic [7:0] to24(input logic [7:0] h);
    logic [6:0] b;
    b = bcd2bin({3'h0, h[4:0]});
    if (b == 7'd12) begin
      b = 7'd0;
    end
    if (h[rcc_pkg::BIT_PM]) begin
      b = 7'(b + 7'd12);
    end
    return bin2bcd(b);
  endfunction

  function automatic logic [7:0] to12(input logic [7:0] h);
    logic [6:0] b;
    logic       pm;
    logic [7:0] d;
    b  = bcd2bin(h);
    pm = (b >= 7'd12);
    b  = 7'(b % 7'd12);
    if (b == 7'd0) begin
      b = 7'd12;
    end
    d  = bin2bcd(b);
    return {2'h0, pm, d[4:0]};
  endfunction

  function automatic logic leap(input logic [7:0] y);
    logic [3:0] u;
    u = y[3:0];
    if (y[4]) begin
      return (u == 4'h2) || (u == 4'h6);
    end
    return (u == 4'h0) || (u == 4'h4) || (u == 4'h8);
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    logic [7:0] r;
    case (m)
      8'h02: begin
        r = leap(y) ? 8'h29 : 8'h28;
      end
      8'h04, 8'h06, 8'h09, 8'h11: begin
        r = 8'h30;
      end
      default: begin
        r = 8'h31;
      end
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]      cnt_reg [rcc_pkg::NUM_CNT];
  logic [7:0]      cnt_next [rcc_pkg::NUM_CNT];
  logic [15:0]     sub_reg;
  logic [15:0]     sub_next;
  logic            held_reg;
  logic            held_next;
  rcc_pkg::rcc_wr_t buf_reg;
  rcc_pkg::rcc_wr_t buf_next;
  logic            run_reg;
  logic            fmt_reg;
  logic            wait_reg;
  logic            wst_reg;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire logic       hit_sec   = (I_ADDR == rcc_pkg::ADDR_SEC);
  wire logic       hit_min   = (I_ADDR == rcc_pkg::ADDR_MIN);
  wire logic       hit_hour  = (I_ADDR == rcc_pkg::ADDR_HOUR);
  wire logic       hit_week  = (I_ADDR == rcc_pkg::ADDR_WEEK);
  wire logic       hit_day   = (I_ADDR == rcc_pkg::ADDR_DAY);
  wire logic       hit_month = (I_ADDR == rcc_pkg::ADDR_MONTH);
  wire logic       hit_year  = (I_ADDR == rcc_pkg::ADDR_YEAR);
  wire logic       hit_c0    = (I_ADDR == rcc_pkg::ADDR_CTRL0);
  wire logic       hit_c1    = (I_ADDR == rcc_pkg::ADDR_CTRL1);
  wire logic       hit_cnt   = hit_sec | hit_min | hit_hour | hit_week
                             | hit_day | hit_month | hit_year;
  wire logic [2:0] hit_idx   =
      hit_sec   ? rcc_pkg::IDX_SEC   :
      hit_min   ? rcc_pkg::IDX_MIN   :
      hit_hour  ? rcc_pkg::IDX_HOUR  :
      hit_week  ? rcc_pkg::IDX_WEEK  :
      hit_day   ? rcc_pkg::IDX_DAY   :
      hit_month ? rcc_pkg::IDX_MONTH : rcc_pkg::IDX_YEAR;
  wire logic       wr_c0     = I_WR & hit_c0;
  wire logic       wr_c1     = I_WR & hit_c1;

  // ------------------------------------------------------------
  // buffered write landing this cycle
  // ------------------------------------------------------------
  wire logic       land      = buf_reg.valid;
  wire logic       land_sec  = land & (buf_reg.idx == rcc_pkg::IDX_SEC);
  wire logic       land_min  = land & (buf_reg.idx == rcc_pkg::IDX_MIN);
  wire logic       land_hour = land & (buf_reg.idx == rcc_pkg::IDX_HOUR);
  wire logic       land_day  = land & (buf_reg.idx == rcc_pkg::IDX_DAY);
  wire logic       land_mon  = land & (buf_reg.idx == rcc_pkg::IDX_MONTH);

  // ------------------------------------------------------------
  // sub-second counter and held overflow
  // ------------------------------------------------------------
  wire logic       sub_ovf   = run_reg & (sub_reg == SUBSEC_LIMIT);
  wire logic       tick      = run_reg & ~wait_reg
                             & (sub_ovf | held_reg);

  always_comb begin
    sub_next = sub_reg;
    if (land_sec) begin
      sub_next = 16'h0000;
    end else if (sub_ovf) begin
      sub_next = 16'h0000;
    end else if (run_reg) begin
      sub_next = 16'(sub_reg + 16'h0001);
    end
  end

  always_comb begin
    held_next = held_reg;
    if (land_sec) begin
      held_next = 1'b0;
    end else if (sub_ovf & wait_reg) begin
      held_next = 1'b1;
    end else if (tick) begin
      held_next = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // carry chain
  // ------------------------------------------------------------
  wire logic [7:0] sec_v   = cnt_reg[rcc_pkg::IDX_SEC];
  wire logic [7:0] min_v   = cnt_reg[rcc_pkg::IDX_MIN];
  wire logic [7:0] hour_v  = cnt_reg[rcc_pkg::IDX_HOUR];
  wire logic [7:0] week_v  = cnt_reg[rcc_pkg::IDX_WEEK];
  wire logic [7:0] day_v   = cnt_reg[rcc_pkg::IDX_DAY];
  wire logic [7:0] mon_v   = cnt_reg[rcc_pkg::IDX_MONTH];
  wire logic [7:0] year_v  = cnt_reg[rcc_pkg::IDX_YEAR];
  wire logic [7:0] hour24  = fmt_reg ? hour_v : to24(hour_v);
  wire logic [7:0] dim     = last_day(mon_v, year_v);
  wire logic       c_min   = tick & ~land_sec
                           & (sec_v == rcc_pkg::MAX_SEC);
  wire logic       c_hour  = c_min & ~land_min
                           & (min_v == rcc_pkg::MAX_SEC);
  wire logic       c_day   = c_hour & ~land_hour
                           & (hour24 == 8'h23);
  wire logic       c_mon   = c_day & ~land_day & (day_v == dim);
  wire logic       c_year  = c_mon & ~land_mon
                           & (mon_v == rcc_pkg::MAX_MONTH);

  // ------------------------------------------------------------
  // incremented values with wrap
  // ------------------------------------------------------------
  wire logic [7:0] hour24_inc = (hour24 == 8'h23) ? 8'h00
                              : bcd_inc(hour24);
  wire logic [7:0] inc_sec  = bcd_wrap(sec_v, rcc_pkg::MAX_SEC,
                                       rcc_pkg::ZERO_BYTE);
  wire logic [7:0] inc_min  = bcd_wrap(min_v, rcc_pkg::MAX_SEC,
                                       rcc_pkg::ZERO_BYTE);
  wire logic [7:0] inc_hour = fmt_reg ? hour24_inc
                            : to12(hour24_inc);
  wire logic [7:0] inc_week = (week_v == rcc_pkg::MAX_WEEK)
                            ? rcc_pkg::ZERO_BYTE
                            : 8'(week_v + 8'h01);
  wire logic [7:0] inc_day  = bcd_wrap(day_v, dim,
                                       rcc_pkg::FIRST_ONE);
  wire logic [7:0] inc_mon  = bcd_wrap(mon_v, rcc_pkg::MAX_MONTH,
                                       rcc_pkg::FIRST_ONE);
  wire logic [7:0] inc_year = bcd_wrap(year_v, rcc_pkg::MAX_YEAR,
                                       rcc_pkg::ZERO_BYTE);

  // ------------------------------------------------------------
  // hour format change
  // ------------------------------------------------------------
  wire logic       fmt_new  = I_WDATA[rcc_pkg::BIT_HOUR_FMT];
  wire logic       fmt_chg  = wr_c0 & (fmt_new != fmt_reg);
  wire logic [7:0] hour_wr  = buf_reg.data
                            & rcc_pkg::CNT_MASK[rcc_pkg::IDX_HOUR];
  wire logic [7:0] hour_src = land_hour ? hour_wr : hour_v;
  wire logic [7:0] hour_cvt = fmt_new ? to24(hour_src)
                            : to12(hour_src);

  // ------------------------------------------------------------
  // counter next values
  // ------------------------------------------------------------
  wire logic [6:0] carry_in = {c_year, c_mon, c_day, c_day,
                               c_hour, c_min, tick};
  logic [7:0]      inc_val [rcc_pkg::NUM_CNT];
  assign inc_val[rcc_pkg::IDX_SEC]   = inc_sec;
  assign inc_val[rcc_pkg::IDX_MIN]   = inc_min;
  assign inc_val[rcc_pkg::IDX_HOUR]  = inc_hour;
  assign inc_val[rcc_pkg::IDX_WEEK]  = inc_week;
  assign inc_val[rcc_pkg::IDX_DAY]   = inc_day;
  assign inc_val[rcc_pkg::IDX_MONTH] = inc_mon;
  assign inc_val[rcc_pkg::IDX_YEAR]  = inc_year;

  always_comb begin
    for (int i = 0; i < rcc_pkg::NUM_CNT; i++) begin
      if (fmt_chg && (i == int'(rcc_pkg::IDX_HOUR))) begin
        cnt_next[i] = hour_cvt;
      end else if (land && (buf_reg.idx == 3'(i))) begin
        cnt_next[i] = buf_reg.data & rcc_pkg::CNT_MASK[i];
      end else if (carry_in[i]) begin
        cnt_next[i] = inc_val[i];
      end else begin
        cnt_next[i] = cnt_reg[i];
      end
    end
  end

  // ------------------------------------------------------------
  // write buffer and read mux
  // ------------------------------------------------------------
  always_comb begin
    buf_next = '0;
    if (I_WR & hit_cnt) begin
      buf_next.valid = 1'b1;
      buf_next.idx   = hit_idx;
      buf_next.data  = I_WDATA;
    end
  end

  wire logic [7:0] ctrl0_rd = {run_reg, 3'h0, fmt_reg, 3'h0};
  wire logic [7:0] ctrl1_rd = {6'h00, wst_reg, wait_reg};

  always_comb begin
    rdata_next = 8'h00;
    if (I_RD) begin
      if (hit_cnt) begin
        rdata_next = cnt_reg[hit_idx];
      end else if (hit_c0) begin
        rdata_next = ctrl0_rd;
      end else if (hit_c1) begin
        rdata_next = ctrl1_rd;
      end
    end
  end

  assign O_RDATA = rdata_reg;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < rcc_pkg::NUM_CNT; i++) begin
        cnt_reg[i] <= rcc_pkg::CNT_RST[i];
      end
    end else begin
      for (int i = 0; i < rcc_pkg::NUM_CNT; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sub_reg  <= 16'h0000;
      held_reg <= 1'b0;
      buf_reg  <= '0;
    end else begin
      sub_reg  <= sub_next;
      held_reg <= held_next;
      buf_reg  <= buf_next;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      run_reg <= 1'b0;
      fmt_reg <= 1'b0;
    end else if (wr_c0) begin
      run_reg <= I_WDATA[rcc_pkg::BIT_RUN_EN];
      fmt_reg <= fmt_new;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      wait_reg <= 1'b0;
      wst_reg  <= 1'b0;
    end else begin
      if (wr_c1) begin
        wait_reg <= I_WDATA[rcc_pkg::BIT_WAIT_CTL];
      end
      wst_reg <= wait_reg;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

endmodule

// ### verification/rcc_calendar_asserts.sv
// checker of the calendar counter chain: read data against strobes
// assumes it is bound to rcc_calendar and sees only its ports
module rcc_calendar_asserts #(
  parameter logic [15:0] SUBSEC_LIMIT = rcc_pkg::SUBSEC_DEF
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic [19:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [7:0]  O_RDATA
);
  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------
  wire logic rd_sec = I_RD && I_ADDR == rcc_pkg::ADDR_SEC;
  wire logic rd_min = I_RD && I_ADDR == rcc_pkg::ADDR_MIN;
  wire logic rd_hour = I_RD && I_ADDR == rcc_pkg::ADDR_HOUR;
  wire logic rd_week = I_RD && I_ADDR == rcc_pkg::ADDR_WEEK;
  wire logic rd_day = I_RD && I_ADDR == rcc_pkg::ADDR_DAY;
  wire logic rd_mon = I_RD && I_ADDR == rcc_pkg::ADDR_MONTH;
  wire logic ctl1 = I_ADDR == rcc_pkg::ADDR_CTRL1;
  wire logic mapped = (I_ADDR >= rcc_pkg::ADDR_SEC &&
                       I_ADDR <= rcc_pkg::ADDR_YEAR) ||
                      I_ADDR == rcc_pkg::ADDR_CTRL0 || ctl1;
  wire logic bcd_ok = O_RDATA[3:0] <= 4'h9;

  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_year_wr;
    I_WR && I_ADDR == rcc_pkg::ADDR_YEAR && I_WDATA[3:0] <= 4'h9 &&
    I_WDATA[7:4] <= 4'h9;
  endsequence
  sequence s_year_rd;
    I_RD && I_ADDR == rcc_pkg::ADDR_YEAR;
  endsequence
  sequence s_wait_on;
    I_WR && ctl1 && I_WDATA[rcc_pkg::BIT_WAIT_CTL];
  endsequence
  sequence s_wait_rd;
    !(I_WR && ctl1) ##1 (I_RD && ctl1);
  endsequence

  property p_idle_zero;
    !I_RD |=> O_RDATA == 8'h00;
  endproperty
  property p_unmapped;
    I_RD && !mapped |=> O_RDATA == 8'h00;
  endproperty
  property p_sec_rng;
    rd_sec |=> O_RDATA <= 8'h59 && bcd_ok;
  endproperty
  property p_min_rng;
    rd_min |=> O_RDATA <= 8'h59 && bcd_ok;
  endproperty
  property p_hour_rng;
    rd_hour |=> O_RDATA <= 8'h32 && bcd_ok;
  endproperty
  property p_week_rng;
    rd_week |=> O_RDATA <= 8'h06;
  endproperty
  property p_day_rng;
    rd_day |=> O_RDATA >= 8'h01 && O_RDATA <= 8'h31 && bcd_ok;
  endproperty
  property p_mon_rng;
    rd_mon |=> O_RDATA >= 8'h01 && O_RDATA <= 8'h12 && bcd_ok;
  endproperty
  property p_wr_live;
    s_year_wr ##2 s_year_rd |=> O_RDATA == $past(I_WDATA, 3);
  endproperty
  property p_wait_st;
    s_wait_on ##1 s_wait_rd |=> O_RDATA[rcc_pkg::BIT_WAIT_ST];
  endproperty

  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero outside read cycle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_sec_rng: assert property (p_sec_rng)
    else $error("seconds out of range");
  a_min_rng: assert property (p_min_rng)
    else $error("minutes out of range");
  a_hour_rng: assert property (p_hour_rng)
    else $error("hours out of range");
  a_week_rng: assert property (p_week_rng)
    else $error("weekday out of range");
  a_day_rng: assert property (p_day_rng)
    else $error("day out of range");
  a_mon_rng: assert property (p_mon_rng)
    else $error("month out of range");
  a_wr_live: assert property (p_wr_live)
    else $error("written year not live two cycles later");
  a_wait_st: assert property (p_wait_st)
    else $error("wait status not set after wait control");
endmodule

bind rcc_calendar rcc_calendar_asserts #(
  .SUBSEC_LIMIT(SUBSEC_LIMIT)
) rcc_calendar_asserts_i (
  .I_CLK   (I_CLK),
  .I_RST   (I_RST),
  .I_ADDR  (I_ADDR),
  .I_WDATA (I_WDATA),
  .I_WR    (I_WR),
  .I_RD    (I_RD),
  .O_RDATA (O_RDATA)
);

// ### verification/rcc_calendar_tb_top.sv
// self-checking bench of the calendar counter chain
// assumes rcc_pkg, rcc_calendar and its checker are compiled first
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end

module rcc_calendar_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CLK;
  logic        I_RST;
  logic        I_WR;
  logic        I_RD;
  logic [19:0] I_ADDR;
  logic [7:0]  I_WDATA;
  logic [7:0]  O_RDATA;
  logic [71:0] cases [9];
  int          mismatches;
  int          n_checks;
  int          cycles;

  rcc_calendar #(.SUBSEC_LIMIT(16'h0003)) rcc_calendar_i (
    .I_CLK   (I_CLK),
    .I_RST   (I_RST),
    .I_ADDR  (I_ADDR),
    .I_WDATA (I_WDATA),
    .I_WR    (I_WR),
    .I_RD    (I_RD),
    .O_RDATA (O_RDATA)
  );

  always #2 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    I_WR <= 1'b1;
    I_RD <= 1'b0;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
  endtask
  task automatic idle(input int n);
    I_WR <= 1'b0;
    I_RD <= 1'b0;
    repeat (n) @(posedge I_CLK);
  endtask
  task automatic chk(input logic [19:0] a, input logic [7:0] e,
                     input string nm);
    I_WR <= 1'b0;
    I_RD <= 1'b0;
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    @(negedge I_CLK);
    `CHK(nm, e, O_RDATA)
    @(posedge I_CLK);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one second step from hh:59:59: format, hour, year, month, day, then
  // expected hour, day, month, year
  task automatic step(input logic [71:0] c);
    logic [7:0] wk;
    wk = (c[39:32] !== c[23:16]) ? 8'h00 : 8'h06;
    wr(rcc_pkg::ADDR_CTRL0, c[71:64]);
    wr(rcc_pkg::ADDR_YEAR, c[55:48]);
    wr(rcc_pkg::ADDR_MONTH, c[47:40]);
    wr(rcc_pkg::ADDR_DAY, c[39:32]);
    wr(rcc_pkg::ADDR_WEEK, 8'h06);
    wr(rcc_pkg::ADDR_HOUR, c[63:56]);
    wr(rcc_pkg::ADDR_MIN, 8'h59);
    wr(rcc_pkg::ADDR_SEC, 8'h59);
    wr(rcc_pkg::ADDR_CTRL0, c[71:64] | 8'h80);
    idle(5);
    wr(rcc_pkg::ADDR_CTRL0, c[71:64]);
    chk(rcc_pkg::ADDR_SEC, 8'h00, "sec");
    chk(rcc_pkg::ADDR_MIN, 8'h00, "min");
    chk(rcc_pkg::ADDR_HOUR, c[31:24], "hour");
    chk(rcc_pkg::ADDR_WEEK, wk, "week");
    chk(rcc_pkg::ADDR_DAY, c[23:16], "day");
    chk(rcc_pkg::ADDR_MONTH, c[15:8], "month");
    chk(rcc_pkg::ADDR_YEAR, c[7:0], "year");
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    cases[0] = {8'h08, 8'h23, 8'h99, 8'h12, 8'h31, 32'h0001_0100};
    cases[1] = {8'h08, 8'h23, 8'h04, 8'h02, 8'h28, 32'h0029_0204};
    cases[2] = {8'h08, 8'h23, 8'h00, 8'h02, 8'h29, 32'h0001_0300};
    cases[3] = {8'h08, 8'h23, 8'h03, 8'h02, 8'h28, 32'h0001_0303};
    cases[4] = {8'h08, 8'h23, 8'h03, 8'h04, 8'h30, 32'h0001_0503};
    cases[5] = {8'h08, 8'h23, 8'h03, 8'h01, 8'h30, 32'h0031_0103};
    cases[6] = {8'h00, 8'h11, 8'h03, 8'h01, 8'h05, 32'h3205_0103};
    cases[7] = {8'h00, 8'h32, 8'h03, 8'h01, 8'h05, 32'h2105_0103};
    cases[8] = {8'h00, 8'h31, 8'h03, 8'h01, 8'h05, 32'h1206_0103};
    I_CLK = 1'b0;
    I_RST = 1'b1;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_ADDR = 20'h0_0000;
    I_WDATA = 8'h00;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    repeat (4) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(posedge I_CLK);
    for (int i = 0; i < rcc_pkg::NUM_CNT; i++) begin
      chk(rcc_pkg::ADDR_SEC + 20'(i), rcc_pkg::CNT_RST[i], "rst");
    end
    chk(20'hF_FF99, 8'h00, "unmapped");
    $display("test reset done");
    wr(rcc_pkg::ADDR_CTRL0, 8'h08);
    chk(rcc_pkg::ADDR_HOUR, 8'h00, "hour24");
    wr(rcc_pkg::ADDR_HOUR, 8'h15);
    chk(rcc_pkg::ADDR_HOUR, 8'h15, "hourwr");
    wr(rcc_pkg::ADDR_CTRL0, 8'h00);
    chk(rcc_pkg::ADDR_HOUR, 8'h23, "to12");
    wr(rcc_pkg::ADDR_CTRL0, 8'h08);
    chk(rcc_pkg::ADDR_HOUR, 8'h15, "to24");
    wr(rcc_pkg::ADDR_HOUR, 8'h00);
    wr(rcc_pkg::ADDR_CTRL0, 8'h00);
    chk(rcc_pkg::ADDR_HOUR, 8'h12, "midnight");
    wr(rcc_pkg::ADDR_YEAR, 8'h42);
    chk(rcc_pkg::ADDR_YEAR, 8'h42, "yearwr");
    wr(rcc_pkg::ADDR_WEEK, 8'hF5);
    chk(rcc_pkg::ADDR_WEEK, 8'h05, "weekmask");
    wr(rcc_pkg::ADDR_CTRL1, 8'h01);
    chk(rcc_pkg::ADDR_CTRL1, 8'h03, "waitst");
    wr(rcc_pkg::ADDR_CTRL1, 8'h00);
    $display("test format and wait done");
    for (int i = 0; i < 9; i++) begin
      step(cases[i]);
    end
    $display("test rollover done");
    wr(rcc_pkg::ADDR_SEC, 8'h10);
    wr(rcc_pkg::ADDR_CTRL1, 8'h01);
    wr(rcc_pkg::ADDR_CTRL0, 8'h80);
    chk(rcc_pkg::ADDR_SEC, 8'h10, "frozen");
    wr(rcc_pkg::ADDR_CTRL1, 8'h00);
    wr(rcc_pkg::ADDR_CTRL0, 8'h00);
    chk(rcc_pkg::ADDR_SEC, 8'h11, "held");
    wr(rcc_pkg::ADDR_CTRL1, 8'h01);
    wr(rcc_pkg::ADDR_CTRL0, 8'h80);
    idle(5);
    wr(rcc_pkg::ADDR_SEC, 8'h20);
    wr(rcc_pkg::ADDR_CTRL1, 8'h00);
    wr(rcc_pkg::ADDR_CTRL0, 8'h00);
    chk(rcc_pkg::ADDR_SEC, 8'h20, "dropped");
    $display("test wait hold done");
    end_of_test();
  end
endmodule
